// >>> core/frpes_op_timer.sv
// Duration counter for one erase or row-program cycle of the flash array
`timescale 1ns/1ps
module frpes_op_timer import frpes_pkg::*; #(
  parameter int unsigned ERASE_CNT = ERASE_CYCLES,
  parameter int unsigned PROG_CNT  = PROG_CYCLES
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic start,
  input  wire logic is_erase,
  output logic      busy,
  output logic      done
);
  // Zero would wrap the down-counter
  if (ERASE_CNT < 1 || PROG_CNT < 1) begin : g_bad_count
    $error("frpes_op_timer: counts must be at least 1");
  end

  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_busy;
  logic        next_done;

  always_comb begin
    next_count = count;
    next_busy  = busy;
    next_done  = 1'b0;
    if (start && !busy) begin
      next_busy  = 1'b1;
      next_count = is_erase ? 32'(ERASE_CNT - 1) : 32'(PROG_CNT - 1);
    end else if (busy) begin
      if (count == 32'h0000_0000) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 32'h0000_0000;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      busy  <= next_busy;
      done  <= next_done;
    end
  end
endmodule // frpes_op_timer

// >>> core/frpes_pkg.sv
// Constants, register map and types for the flash row program/erase sequencer
package frpes_pkg;
  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned ERASE_TIME_NS   = 20000000;
  localparam int unsigned PROG_TIME_NS    = 1600000;
  localparam int unsigned ERASE_CYCLES    = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_CYCLES     = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [4:0]  REG_CTRL        = 5'h00;
  localparam logic [4:0]  REG_KEY         = 5'h04;
  localparam logic [4:0]  REG_PAGE_PTR    = 5'h08;
  localparam logic [4:0]  REG_TBLWR       = 5'h0C;
  localparam logic [4:0]  REG_STATUS      = 5'h10;

  // Control fields
  localparam int unsigned CTRL_OP_LSB     = 0;
  localparam int unsigned CTRL_OP_W       = 4;
  localparam int unsigned CTRL_ERASE_BIT  = 6;
  localparam int unsigned CTRL_PROG_EN_BIT = 14;
  localparam int unsigned CTRL_START_BIT  = 15;
  localparam logic [3:0]  OP_ROW          = 4'h1;
  localparam logic [3:0]  OP_ERASE        = 4'h2;

  // Unlock key values
  localparam logic [7:0]  KEY_FIRST       = 8'h55;
  localparam logic [7:0]  KEY_SECOND      = 8'hAA;

  // Geometry: 64 instructions a row, 8 rows a page, two address units each
  localparam int unsigned ROW_ALIGN_BITS  = 7;
  localparam int unsigned PAGE_ALIGN_BITS = 10;
  localparam int unsigned PAGE_W          = 8;
  localparam int unsigned OFFS_W          = 16;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {
    KEY_LOCKED = 2'b00,
    KEY_HALF   = 2'b01,
    KEY_OPEN   = 2'b10
  } frpes_key_t;

  // Word-aligned register decode, shared by read and write paths
  function automatic logic frpes_hit(input logic [4:0] addr, input logic [4:0] reg_off);
    return addr[4:2] == reg_off[4:2];
  endfunction
endpackage

// >>> core/frpes_seq.sv
// Flash program/erase sequencer with AXI4-Lite register access
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module frpes_seq import frpes_pkg::*; #(
  parameter int unsigned ERASE_CNT = ERASE_CYCLES,
  parameter int unsigned PROG_CNT  = PROG_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             cpu_stall,
  output logic             flash_erase_en,
  output logic             flash_prog_en,
  output logic [23:0]      flash_addr
);
  logic             aw_held, w_held;
  logic [4:0]       aw_addr;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic [3:0]       ctrl_op;
  logic             ctrl_erase, ctrl_prog_en, ctrl_start;
  logic [PAGE_W-1:0] table_page_pointer;
  logic [OFFS_W-1:0] base_offs;
  logic [PAGE_W-1:0] base_page;
  frpes_key_t       key_state;
  logic             rejected;
  logic             tmr_busy, tmr_done, start_go;

  logic             next_aw_held, next_w_held, next_awready, next_wready, next_bvalid;
  logic             next_arready, next_rvalid;
  logic [1:0]       next_bresp, next_rresp;
  logic [31:0]      next_rdata;
  logic [4:0]       next_aw_addr;
  logic [31:0]      next_w_data;
  logic [3:0]       next_w_strb;
  logic [3:0]       next_ctrl_op;
  logic             next_ctrl_erase, next_ctrl_prog_en, next_ctrl_start;
  logic [PAGE_W-1:0] next_tpp, next_base_page;
  logic [OFFS_W-1:0] next_base_offs;
  frpes_key_t       next_key_state;
  logic             next_rejected, next_start_go;
  logic             next_erase_en, next_prog_en, next_stall;
  logic [23:0]      next_flash_addr;

  logic             wr_fire, rd_fire, op_ok, merge_start;
  logic [15:0]      ctrl_word, ctrl_merged;

  frpes_op_timer #(
    .ERASE_CNT (ERASE_CNT),
    .PROG_CNT  (PROG_CNT)
  ) u_timer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .start    (start_go),
    .is_erase (ctrl_erase),
    .busy     (tmr_busy),
    .done     (tmr_done)
  );

  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_OP_LSB +: CTRL_OP_W] = ctrl_op;
    ctrl_word[CTRL_ERASE_BIT] = ctrl_erase;
    ctrl_word[CTRL_PROG_EN_BIT] = ctrl_prog_en;
    ctrl_word[CTRL_START_BIT] = ctrl_start;
    ctrl_merged[7:0]  = w_strb[0] ? w_data[7:0]  : ctrl_word[7:0];
    ctrl_merged[15:8] = w_strb[1] ? w_data[15:8] : ctrl_word[15:8];
    merge_start = ctrl_merged[CTRL_START_BIT];
    wr_fire = aw_held && w_held && !s_axi_bvalid;
    rd_fire = s_axi_arvalid && s_axi_arready;

    next_aw_held    = aw_held || (s_axi_awvalid && s_axi_awready);
    next_w_held     = w_held || (s_axi_wvalid && s_axi_wready);
    next_aw_addr    = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr;
    next_w_data     = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data;
    next_w_strb     = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : w_strb;
    next_bvalid     = s_axi_bvalid && !s_axi_bready;
    next_bresp      = s_axi_bresp;
    next_rvalid     = s_axi_rvalid && !s_axi_rready;
    next_rdata      = s_axi_rdata;
    next_rresp      = s_axi_rresp;
    next_ctrl_op    = ctrl_op;
    next_ctrl_erase = ctrl_erase;
    next_ctrl_prog_en = ctrl_prog_en;
    next_ctrl_start = ctrl_start;
    next_tpp        = table_page_pointer;
    next_base_page  = base_page;
    next_base_offs  = base_offs;
    next_key_state  = key_state;
    next_rejected   = rejected;
    next_start_go   = 1'b0;
    op_ok           = 1'b0;

    if (tmr_done) begin
      next_ctrl_start = 1'b0;
    end

    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      // any write other than the key sequence closes the unlock
      next_key_state = KEY_LOCKED;
      if (frpes_hit(aw_addr, REG_CTRL)) begin
        // Settings frozen while an operation runs
        if (!ctrl_start) begin
          next_ctrl_op    = ctrl_merged[CTRL_OP_LSB +: CTRL_OP_W];
          next_ctrl_erase = ctrl_merged[CTRL_ERASE_BIT];
          next_ctrl_prog_en = ctrl_merged[CTRL_PROG_EN_BIT];
          op_ok = ctrl_merged[CTRL_PROG_EN_BIT] &&
                  ((ctrl_merged[CTRL_OP_LSB +: CTRL_OP_W] == OP_ERASE &&
                    ctrl_merged[CTRL_ERASE_BIT]) ||
                   (ctrl_merged[CTRL_OP_LSB +: CTRL_OP_W] == OP_ROW &&
                    !ctrl_merged[CTRL_ERASE_BIT]));
          if (merge_start) begin
            if (key_state == KEY_OPEN && op_ok) begin
              next_ctrl_start = 1'b1;
              next_start_go   = 1'b1;
              next_rejected   = 1'b0;
            end else begin
              next_rejected = 1'b1;
            end
          end
        end
      end else if (frpes_hit(aw_addr, REG_KEY)) begin
        if (w_strb[0] && w_data[7:0] == KEY_FIRST) begin
          next_key_state = KEY_HALF;
        end else if (w_strb[0] && w_data[7:0] == KEY_SECOND && key_state == KEY_HALF) begin
          next_key_state = KEY_OPEN;
        end
      end else if (frpes_hit(aw_addr, REG_PAGE_PTR)) begin
        if (w_strb[0]) begin
          next_tpp = w_data[PAGE_W-1:0];
        end
      end else if (frpes_hit(aw_addr, REG_TBLWR)) begin
        // Table write latches the erase base
        next_base_page = table_page_pointer;
        next_base_offs = w_data[OFFS_W-1:0];
      end else if (!frpes_hit(aw_addr, REG_STATUS)) begin
        next_bresp = RESP_SLVERR;
      end
    end

    // Only one of each channel in flight: ready drops while holding or answering
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid && !rd_fire;

    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      if (frpes_hit(s_axi_araddr, REG_CTRL)) begin
        next_rdata[15:0] = ctrl_word;
      end else if (frpes_hit(s_axi_araddr, REG_PAGE_PTR)) begin
        next_rdata[PAGE_W-1:0] = table_page_pointer;
      end else if (frpes_hit(s_axi_araddr, REG_TBLWR)) begin
        next_rdata[23:0] = {base_page, base_offs};
      end else if (frpes_hit(s_axi_araddr, REG_STATUS)) begin
        next_rdata[3:0] = {key_state, rejected, ctrl_start};
      end else if (!frpes_hit(s_axi_araddr, REG_KEY)) begin
        next_rresp = RESP_SLVERR;
      end
    end

    // erase spans the page, program one row
    next_erase_en   = next_ctrl_start && next_ctrl_erase;
    next_prog_en    = next_ctrl_start && !next_ctrl_erase;
    next_flash_addr = {next_base_page, next_base_offs};
    if (next_ctrl_erase) begin
      next_flash_addr[PAGE_ALIGN_BITS-1:0] = '0;
    end else begin
      next_flash_addr[ROW_ALIGN_BITS-1:0] = '0;
    end
    next_stall = next_ctrl_start;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held            <= 1'b0;
      w_held             <= 1'b0;
      aw_addr            <= 5'h00;
      w_data             <= 32'h0000_0000;
      w_strb             <= 4'h0;
      s_axi_awready      <= 1'b0;
      s_axi_wready       <= 1'b0;
      s_axi_bvalid       <= 1'b0;
      s_axi_bresp        <= RESP_OKAY;
      s_axi_arready      <= 1'b0;
      s_axi_rvalid       <= 1'b0;
      s_axi_rdata        <= 32'h0000_0000;
      s_axi_rresp        <= RESP_OKAY;
      ctrl_op            <= 4'h0;
      ctrl_erase         <= 1'b0;
      ctrl_prog_en       <= 1'b0;
      ctrl_start         <= 1'b0;
      table_page_pointer <= '0;
      base_page          <= '0;
      base_offs          <= '0;
      key_state          <= KEY_LOCKED;
      rejected           <= 1'b0;
      start_go           <= 1'b0;
      flash_erase_en     <= 1'b0;
      flash_prog_en      <= 1'b0;
      flash_addr         <= 24'h00_0000;
      cpu_stall          <= 1'b0;
    end else begin
      aw_held            <= next_aw_held;
      w_held             <= next_w_held;
      aw_addr            <= next_aw_addr;
      w_data             <= next_w_data;
      w_strb             <= next_w_strb;
      s_axi_awready      <= next_awready;
      s_axi_wready       <= next_wready;
      s_axi_bvalid       <= next_bvalid;
      s_axi_bresp        <= next_bresp;
      s_axi_arready      <= next_arready;
      s_axi_rvalid       <= next_rvalid;
      s_axi_rdata        <= next_rdata;
      s_axi_rresp        <= next_rresp;
      ctrl_op            <= next_ctrl_op;
      ctrl_erase         <= next_ctrl_erase;
      ctrl_prog_en       <= next_ctrl_prog_en;
      ctrl_start         <= next_ctrl_start;
      table_page_pointer <= next_tpp;
      base_page          <= next_base_page;
      base_offs          <= next_base_offs;
      key_state          <= next_key_state;
      rejected           <= next_rejected;
      start_go           <= next_start_go;
      flash_erase_en     <= next_erase_en;
      flash_prog_en      <= next_prog_en;
      flash_addr         <= next_flash_addr;
      cpu_stall          <= next_stall;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_start_needs_key: assert property ($rose(ctrl_start) |-> $past(key_state) == KEY_OPEN)
    else $error("start accepted without unlock");
  a_other_write_locks: assert property (wr_fire && !frpes_hit(aw_addr, REG_KEY)
    |=> key_state == KEY_LOCKED) else $error("unlock survived another write");
  a_erase_code: assert property (flash_erase_en |-> ctrl_op == OP_ERASE && ctrl_prog_en)
    else $error("erase without erase code");
  a_prog_code: assert property (flash_prog_en |-> ctrl_op == OP_ROW && !ctrl_erase)
    else $error("program without row code");
  a_stall_span: assert property (tmr_busy |-> ctrl_start ##1 cpu_stall)
    else $error("stall or start dropped during operation");
  a_start_self_clear: assert property (tmr_done |=> !ctrl_start ##1 !cpu_stall)
    else $error("start did not clear after operation");
  a_timer_launch: assert property (start_go |=> tmr_busy && flash_prog_en != flash_erase_en)
    else $error("operation did not launch");
  a_erase_page: assert property (flash_erase_en |-> flash_addr[PAGE_ALIGN_BITS-1:0] == '0)
    else $error("erase address not page aligned");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  c_erase_run: cover property ($rose(flash_erase_en));
  c_prog_run: cover property ($rose(flash_prog_en));
  c_start_refused: cover property ($rose(rejected));
  c_key_half_lost: cover property (key_state == KEY_HALF ##1 key_state == KEY_LOCKED);
endmodule // frpes_seq

// >>> test/flash_row_program_erase_sequencer_tb.sv
// Self-checking bench for the flash program/erase sequencer
`timescale 1ns/1ps
module flash_row_program_erase_sequencer_tb;
  import frpes_pkg::*;
  typedef struct packed {
    logic [7:0]  k1;
    logic [7:0]  k2;
    logic        mid;
    logic [15:0] ctrl;
    logic        ex_e;
    logic        ex_p;
  } frpes_row_t;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [4:0]  awa = 5'h00;
  logic [4:0]  ara = 5'h00;
  logic [31:0] wd = 32'h0;
  logic        awv = 1'b0;
  logic        wv = 1'b0;
  logic        arv = 1'b0;
  logic        awr, wr_rdy, bv, arr, rv, stall, fe, fp;
  logic [1:0]  br, rr;
  logic [31:0] rd;
  logic [23:0] fa;
  int          n_e, n_p, ecyc;
  logic [23:0] la;
  int          n_mismatch = 0;
  int          n_compared = 0;
  frpes_row_t  rows [6];
  logic [1:0]  r;
  logic [31:0] d;
  int          e0, p0;
  logic [3:0]  ws = 4'hF;
  // Erase long enough to read twice while it runs
  localparam int unsigned T_ERASE = 12;
  localparam int unsigned T_PROG  = 3;

  always #5 aclk = ~aclk;

  frpes_seq #(.ERASE_CNT(T_ERASE), .PROG_CNT(T_PROG)) u_frpes_seq (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(1'b1), .cpu_stall(stall),
    .flash_erase_en(fe), .flash_prog_en(fp), .flash_addr(fa)
  );

  frpes_flash_model u_frpes_flash_model (
    .aclk(aclk), .flash_erase_en(fe), .flash_prog_en(fp), .flash_addr(fa),
    .n_erase(n_e), .n_prog(n_p), .en_cyc(ecyc), .last_addr(la)
  );

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awv && awr === 1'b1) begin
        ta = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wr_rdy === 1'b1) begin
        tw = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge aclk); while (bv !== 1'b1);
    resp = br;
  endtask

  task automatic rdr(input logic [4:0] a, output logic [31:0] v, output logic [1:0] resp);
    ara <= a;
    arv <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge aclk); while (rv !== 1'b1);
    v = rd;
    resp = rr;
  endtask

  task automatic wait_idle();
    @(posedge aclk);
    for (int i = 0; i < 40 && stall !== 1'b0; i++) @(posedge aclk);
  endtask

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    rows[0] = '{8'h55, 8'hAA, 1'b0, 16'hC042, 1'b1, 1'b0};
    rows[1] = '{8'h55, 8'hAA, 1'b0, 16'hC001, 1'b0, 1'b1};
    rows[2] = '{8'hAA, 8'h55, 1'b0, 16'hC042, 1'b0, 1'b0};
    rows[3] = '{8'h55, 8'h55, 1'b0, 16'hC001, 1'b0, 1'b0};
    rows[4] = '{8'h55, 8'hAA, 1'b1, 16'hC042, 1'b0, 1'b0};
    rows[5] = '{8'h55, 8'hAA, 1'b0, 16'hC003, 1'b0, 1'b0};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdr(REG_STATUS, d, r);
    chk("status reset", 32'h0, d);
    rdr(5'h14, d, r);
    chk("unmapped read resp", RESP_SLVERR, r);
    rdr(REG_KEY, d, r);
    chk("key read", 32'h0, d);
    wr(REG_PAGE_PTR, 32'h12, r);
    wr(REG_TBLWR, 32'h0400, r);
    rdr(REG_TBLWR, d, r);
    chk("erase base", 32'h120400, d);
    foreach (rows[i]) begin
      e0 = n_e;
      p0 = n_p;
      wr(REG_KEY, rows[i].k1, r);
      wr(REG_KEY, rows[i].k2, r);
      if (rows[i].mid) wr(5'h14, 32'h0, r);
      if (rows[i].mid) chk("unmapped write resp", RESP_SLVERR, r);
      wr(REG_CTRL, rows[i].ctrl, r);
      wait_idle();
      chk("erase count", e0 + rows[i].ex_e, n_e);
      chk("program count", p0 + rows[i].ex_p, n_p);
      rdr(REG_STATUS, d, r);
      chk("start cleared", 1'b0, d[0]);
      chk("rejected flag", !(rows[i].ex_e | rows[i].ex_p), d[1]);
      if (rows[i].ex_e | rows[i].ex_p) begin
        chk("flash address", 32'h120400, la);
        chk("enable span", rows[i].ex_e ? T_ERASE + 2 : T_PROG + 2, ecyc);
      end
    end
    // Running erase: configure, unlock, start; a new control write is ignored
    e0 = n_e;
    wr(REG_CTRL, 32'h4042, r);
    wr(REG_KEY, 32'h55, r);
    wr(REG_KEY, 32'hAA, r);
    wr(REG_CTRL, 32'hC042, r);
    @(posedge aclk);
    chk("stall during erase", 1'b1, stall);
    wr(REG_CTRL, 32'h0, r);
    rdr(REG_CTRL, d, r);
    chk("start while busy", 32'hC042, d);
    rdr(REG_STATUS, d, r);
    chk("busy status", 1'b1, d[0]);
    wait_idle();
    chk("stall released", 1'b0, stall);
    rdr(REG_CTRL, d, r);
    chk("start self clear", 1'b0, d[15]);
    chk("erase count busy case", e0 + 1, n_e);
    // buffers stay in software; rows step the pointer
    for (int j = 1; j < 3; j++) begin
      p0 = n_p;
      wr(REG_PAGE_PTR, 32'(18 + j), r);
      wr(REG_TBLWR, 32'(j * 128 + 21), r);
      wr(REG_KEY, 32'h55, r);
      wr(REG_KEY, 32'hAA, r);
      wr(REG_CTRL, 32'hC001, r);
      wait_idle();
      chk("row program count", p0 + 1, n_p);
      chk("row address", 32'((18 + j) * 65536 + j * 128), la);
    end
    // Key value in an unstrobed byte must not unlock
    p0 = n_p;
    ws <= 4'hE;
    wr(REG_KEY, 32'h55, r);
    ws <= 4'hF;
    wr(REG_KEY, 32'hAA, r);
    wr(REG_CTRL, 32'hC001, r);
    wait_idle();
    chk("unstrobed key", p0, n_p);
    // Reset in mid-erase drops stall and enables and clears the registers
    wr(REG_KEY, 32'h55, r);
    wr(REG_KEY, 32'hAA, r);
    wr(REG_CTRL, 32'hC042, r);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("stall in reset", 1'b0, stall);
    chk("erase enable in reset", 1'b0, fe);
    repeat (14) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdr(REG_STATUS, d, r);
    chk("status after reset", 32'h0, d);
    rdr(REG_TBLWR, d, r);
    chk("base after reset", 32'h0, d);
    print_verdict();
  end
endmodule // flash_row_program_erase_sequencer_tb

// >>> test/frpes_flash_model.sv
// Behavioural flash array seen through the sequencer's enable and address lines
`timescale 1ns/1ps
module frpes_flash_model (
  input  wire logic        aclk,
  input  wire logic        flash_erase_en,
  input  wire logic        flash_prog_en,
  input  wire logic [23:0] flash_addr,
  output int               n_erase,
  output int               n_prog,
  output int               en_cyc,
  output logic [23:0]      last_addr
);
  logic was_e = 1'b0;
  logic was_p = 1'b0;
  initial begin
    n_erase = 0;
    n_prog = 0;
    en_cyc = 0;
    last_addr = 24'h000000;
  end
  // page erase or single row program, counted per operation
  always @(posedge aclk) begin
    if ((flash_erase_en && !was_e) || (flash_prog_en && !was_p)) begin
      en_cyc <= 1;
      last_addr <= flash_addr;
      if (flash_erase_en) n_erase <= n_erase + 1;
      else n_prog <= n_prog + 1;
    end else if (flash_erase_en || flash_prog_en) begin
      en_cyc <= en_cyc + 1;
    end
    was_e <= flash_erase_en;
    was_p <= flash_prog_en;
  end
endmodule // frpes_flash_model
